// ### verilog/sync_tx_pkg.sv
// shared constants and carrier types of the clocked-synchronous transmitter
`default_nettype none
package sync_tx_pkg;

    // ------------------------------------------------------------------
    // register indices (byte address is four times the index)
    // ------------------------------------------------------------------
    localparam logic [23:0] IDX_FORMAT   = 24'hffff88;
    localparam logic [23:0] IDX_RATE     = 24'hffff89;
    localparam logic [23:0] IDX_CONTROL  = 24'hffff8a;
    localparam logic [23:0] IDX_HOLDING  = 24'hffff8b;
    localparam logic [23:0] IDX_FLAGS    = 24'hffff8c;
    localparam logic [23:0] IDX_IRQ_STAT = 24'hffff90;
    localparam logic [23:0] IDX_IRQ_MASK = 24'hffff91;

    // ------------------------------------------------------------------
    // field positions
    // ------------------------------------------------------------------
    localparam int FMT_SYNC_BIT = 7;   // synchronous mode select
    localparam int FMT_PRE_HI   = 1;   // prescale_sel_hi
    localparam int FMT_PRE_LO   = 0;   // prescale_sel_lo
    localparam int CTL_TX_EN    = 5;   // tx_enable
    localparam int CTL_RX_EN    = 4;   // rx_enable
    localparam int CTL_SRC_HI   = 1;   // clock_source_sel_hi
    localparam int CTL_SRC_LO   = 0;   // clock_source_sel_lo
    localparam int FLG_EMPTY    = 7;   // tx_buffer_empty
    localparam int FLG_DONE     = 2;   // tx_done_flag
    localparam int IRQ_EMPTY    = 0;   // byte moved to the shifter
    localparam int IRQ_DONE     = 1;   // transmission ended

    // ------------------------------------------------------------------
    // reset values
    // ------------------------------------------------------------------
    localparam logic [7:0] FORMAT_RST  = 8'h80;
    localparam logic [7:0] RATE_RST    = 8'hff;
    localparam logic [7:0] CONTROL_RST = 8'h00;
    localparam logic [7:0] HOLDING_RST = 8'hff;
    localparam logic [1:0] IRQ_RST     = 2'h0;

    // ------------------------------------------------------------------
    // carriers
    // ------------------------------------------------------------------
    typedef struct packed {
        logic        cyc;
        logic        stb;
        logic        we;
        logic [31:0] adr;
        logic [3:0]  sel;
        logic [31:0] dat;
    } wb_req_t;

    typedef struct packed {
        logic        ack;
        logic [31:0] dat;
    } wb_rsp_t;

    typedef struct packed {
        logic txd;      // serial data out
        logic sck;      // serial clock out
        logic sck_oe;   // serial clock driven by this block
    } serial_pins_t;

endpackage : sync_tx_pkg
`default_nettype wire

// ### verilog/pin_sync.sv
// two-flop synchroniser for pins from outside the clock domain
`timescale 1ns/1ps
`default_nettype none
module pin_sync
    import sync_tx_pkg::*;
#(
    parameter int W = 1
) (
    input  wire logic         clk_i,
    input  wire logic         rst_i,
    input  wire logic [W-1:0] pin_i,
    output logic      [W-1:0] sync_o
);

    if (W < 1) begin : g_chk
        $error("pin_sync needs at least one bit");
    end

    typedef struct packed {
        logic [W-1:0] meta;   // first stage, read only by the second
        logic [W-1:0] sync;
    } sync_st_t;

    sync_st_t st_q;
    sync_st_t st_d;

    // next state
    always_comb begin
        st_d      = st_q;
        st_d.meta = pin_i;
        st_d.sync = st_q.meta;
    end

    // register, ones at reset match an idle high clock
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            st_q <= '1;
        end else begin
            st_q <= st_d;
        end
    end

    assign sync_o = st_q.sync;

endmodule : pin_sync
`default_nettype wire

// ### verilog/tx_rate_gen.sv
// half-bit tick generator: prescaler then rate divisor
`timescale 1ns/1ps
`default_nettype none
module tx_rate_gen
    import sync_tx_pkg::*;
#(
    parameter int DIV_W = 8
) (
    input  wire logic             clk_i,
    input  wire logic             rst_i,
    input  wire logic             run_i,
    input  wire logic [1:0]       pre_sel_i,
    input  wire logic [DIV_W-1:0] divisor_i,
    output logic                  tick_o
);

    if (DIV_W < 1 || DIV_W > 16) begin : g_chk
        $error("tx_rate_gen divisor width must be 1 to 16");
    end

    typedef struct packed {
        logic [7:0]       pre;
        logic [DIV_W-1:0] div;
        logic             tick;
    } rate_st_t;

    rate_st_t st_q;
    rate_st_t st_d;

    // prescale period is 2 * 4^n system clocks
    function automatic logic [7:0] pre_last(input logic [1:0] n);
        pre_last = 8'((9'h002 << {n, 1'b0}) - 9'h001);
    endfunction : pre_last

    // counters free while running, cleared when stopped
    always_comb begin
        st_d      = st_q;
        st_d.tick = 1'b0;
        if (!run_i) begin
            st_d.pre = 8'h00;
            st_d.div = '0;
        end else if (st_q.pre != pre_last(pre_sel_i)) begin
            st_d.pre = st_q.pre + 8'h01;
        end else begin
            st_d.pre = 8'h00;
            if (st_q.div >= divisor_i) begin
                st_d.div  = '0;
                st_d.tick = 1'b1;
            end else begin
                st_d.div = st_q.div + 1'b1;
            end
        end
    end

    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            st_q <= '0;
        end else begin
            st_q <= st_d;
        end
    end

    assign tick_o = st_q.tick;

    // ------------------------------------------------------------------
    // checks: tick spacing while settings stay put
    // ------------------------------------------------------------------
    logic [23:0] gap_q;
    logic        seen_q;
    always_ff @(posedge clk_i) begin
        if (rst_i || !run_i || $changed(divisor_i) || $changed(pre_sel_i)) begin
            gap_q  <= 24'h0;
            seen_q <= 1'b0;
        end else if (tick_o) begin
            gap_q  <= 24'h1;
            seen_q <= 1'b1;
        end else begin
            gap_q <= gap_q + 24'h1;
        end
    end

    chk_tick_spacing: assert property (@(posedge clk_i) disable iff (rst_i)
        (tick_o && seen_q && run_i && $stable(divisor_i) && $stable(pre_sel_i))
        |-> (gap_q == 24'((32'(pre_last(pre_sel_i)) + 1) * (32'(divisor_i) + 1))))
        else $error("half-bit tick spacing wrong");
    chk_fast_rate: assert property (@(posedge clk_i) disable iff (rst_i)
        (tick_o && seen_q && pre_sel_i == 2'h0 && divisor_i == DIV_W'(7) && $stable(divisor_i))
        |-> gap_q == 24'd16)
        else $error("divisor 7 at setting 0 not sixteen clocks per half bit");

endmodule : tx_rate_gen
`default_nettype wire

// ### verilog/sync_serial_transmitter.sv
// clocked-synchronous serial transmit channel with a wishbone register file
`timescale 1ns/1ps
`default_nettype none
// Overview of operation
// - the transmitter idles while tx_enable (control bit 5) is 0 and runs only when it is 1.
// - rx_enable (control bit 4) gates reception and is brought out as a level.
// - with clock_source_sel_hi 0 the block makes its own clock and drives the clock pin.
// - with clock_source_sel_hi 1 the clock pin is an input and shifting follows it.
// - tx_buffer_empty (flags bit 7) reads 0 while a byte waits, and then holding writes are refused.
// - tx_buffer_empty reads 1 once the waiting byte has moved into the shifter.
// - tx_done_flag (flags bit 2) reads 0 while sending and 1 once sending has ended.
// - the holding register is eight bits wide and resets to all ones.
// - an eight-bit rate divisor with the prescale setting sets the bit rate.
// - the rate divisor can be read and written at any time.
// - the divisor gives the tabled rates, e.g. value 15 at setting 0 is a quarter of the base rate of value 3.
// - a waiting byte is copied into the shifter, the empty flag is set and shifting begins.
// - a frame is eight data bits on the data pin in step with the serial clock.
// - at the final bit a waiting byte is loaded and sent with no gap.
// - with no byte waiting at the final bit the done flag sets, data holds and the clock stays high.
module sync_serial_transmitter
    import sync_tx_pkg::*;
(
    input  wire logic         clk_i,
    input  wire logic         rst_i,
    input  wire wb_req_t      wb_i,
    output wb_rsp_t           wb_o,
    input  wire logic         sck_i,
    output serial_pins_t      pins_o,
    output logic              rx_enable_o,
    output logic              irq_o
);

    typedef enum logic [0:0] {
        ST_IDLE  = 1'b0,
        ST_SHIFT = 1'b1
    } tx_state_t;

    typedef struct packed {
        logic        ack;
        logic [31:0] rdat;
        logic [7:0]  fmt;
        logic [7:0]  ctl;
        logic [7:0]  hold;
        logic [7:0]  rate;
        logic [7:0]  shft;
        logic        tx_buffer_empty;
        logic        tx_done_flag;
        tx_state_t   state;
        logic [2:0]  bitn;
        logic        sck;
        logic        sck_oe;
        logic        txd;
        logic        ext_prev;
        logic [1:0]  ist;
        logic [1:0]  imask;
        logic        irq;
    } core_st_t;

    core_st_t st_q;
    core_st_t st_d;

    // ------------------------------------------------------------------
    // helpers
    // ------------------------------------------------------------------

    // word address match for one register index
    function automatic logic hit(input logic [31:0] adr, input logic [23:0] idx);
        hit = (adr[31:26] == 6'h00) && (adr[25:2] == idx);
    endfunction : hit

    // widen a byte into the low lane of the read word
    function automatic logic [31:0] lane0(input logic [7:0] b);
        lane0 = {24'h000000, b};
    endfunction : lane0

    // ------------------------------------------------------------------
    // clock pin synchroniser and half-bit tick
    // ------------------------------------------------------------------
    logic ext_sck;
    logic half_tick;
    logic ext_mode;
    logic tx_on;
    logic pending;
    logic run;

    assign ext_mode = st_q.ctl[CTL_SRC_HI];
    assign tx_on    = st_q.ctl[CTL_TX_EN];
    assign pending  = tx_on && !st_q.tx_buffer_empty;
    assign run      = !ext_mode && tx_on && (st_q.state == ST_SHIFT || pending);

    pin_sync #(
        .W (1)
    ) u_sck_sync (
        .clk_i  (clk_i),
        .rst_i  (rst_i),
        .pin_i  (sck_i),
        .sync_o (ext_sck)
    );

    tx_rate_gen #(
        .DIV_W (8)
    ) u_rate (
        .clk_i     (clk_i),
        .rst_i     (rst_i),
        .run_i     (run),
        .pre_sel_i ({st_q.fmt[FMT_PRE_HI], st_q.fmt[FMT_PRE_LO]}),
        .divisor_i (st_q.rate),
        .tick_o    (half_tick)
    );

    // ------------------------------------------------------------------
    // next state: bus slave, shifter, flags, interrupts
    // ------------------------------------------------------------------
    logic       req;
    logic       wr;
    logic       fall_ev;
    logic       rise_ev;
    logic [1:0] ist_set;
    logic [1:0] ist_clr;
    logic       load_ev;

    always_comb begin
        st_d     = st_q;
        ist_set  = 2'b00;
        ist_clr  = 2'b00;
        load_ev  = 1'b0;
        st_d.ack = 1'b0;
        req      = wb_i.cyc && wb_i.stb && !st_q.ack;
        wr       = req && wb_i.we && wb_i.sel[0];

        // clock edges: own divider or the synchronised pin
        fall_ev = ext_mode ? (st_q.ext_prev && !ext_sck) : (half_tick && st_q.sck);
        rise_ev = ext_mode ? (!st_q.ext_prev && ext_sck) : (half_tick && !st_q.sck);
        st_d.ext_prev = ext_sck;

        // register reads answer one cycle after the request
        if (req) begin
            st_d.ack  = 1'b1;
            st_d.rdat = 32'h00000000;
            if (hit(wb_i.adr, IDX_FORMAT)) begin
                st_d.rdat = lane0(st_q.fmt);
            end else if (hit(wb_i.adr, IDX_RATE)) begin
                st_d.rdat = lane0(st_q.rate);
            end else if (hit(wb_i.adr, IDX_CONTROL)) begin
                st_d.rdat = lane0(st_q.ctl);
            end else if (hit(wb_i.adr, IDX_HOLDING)) begin
                st_d.rdat = lane0(st_q.hold);
            end else if (hit(wb_i.adr, IDX_FLAGS)) begin
                st_d.rdat = lane0({st_q.tx_buffer_empty, 4'h0, st_q.tx_done_flag, 2'h0});
            end else if (hit(wb_i.adr, IDX_IRQ_STAT)) begin
                st_d.rdat = {30'h0, st_q.ist};
            end else if (hit(wb_i.adr, IDX_IRQ_MASK)) begin
                st_d.rdat = {30'h0, st_q.imask};
            end
        end

        // register writes
        if (wr) begin
            if (hit(wb_i.adr, IDX_FORMAT)) begin
                st_d.fmt = wb_i.dat[7:0];
            end
            if (hit(wb_i.adr, IDX_RATE)) begin
                st_d.rate = wb_i.dat[7:0];
            end
            if (hit(wb_i.adr, IDX_CONTROL)) begin
                st_d.ctl = wb_i.dat[7:0];
            end
            if (hit(wb_i.adr, IDX_HOLDING) && st_q.tx_buffer_empty) begin
                st_d.hold = wb_i.dat[7:0];
            end
            if (hit(wb_i.adr, IDX_FLAGS) && !wb_i.dat[FLG_EMPTY] && st_q.tx_buffer_empty) begin
                st_d.tx_buffer_empty = 1'b0;                                 // byte handed over
                st_d.tx_done_flag = 1'b0;
            end
            if (hit(wb_i.adr, IDX_IRQ_STAT)) begin
                ist_clr = wb_i.dat[1:0];
            end
            if (hit(wb_i.adr, IDX_IRQ_MASK)) begin
                st_d.imask = wb_i.dat[1:0];
            end
        end

        // falling edge: shift the next bit, load a waiting byte or stop
        if (fall_ev) begin
            if (st_q.state == ST_SHIFT && st_q.bitn != 3'h7) begin
                st_d.shft = {1'b1, st_q.shft[7:1]};
                st_d.txd  = st_q.shft[1];
                st_d.bitn = st_q.bitn + 3'h1;
                st_d.sck  = ext_mode;
            end else if (pending) begin
                load_ev    = 1'b1;
                st_d.shft  = st_q.hold;
                st_d.txd   = st_q.hold[0];
                st_d.bitn  = 3'h0;
                st_d.state = ST_SHIFT;
                st_d.tx_buffer_empty  = 1'b1;
                st_d.tx_done_flag  = 1'b0;
                st_d.sck   = ext_mode;
                ist_set[IRQ_EMPTY] = 1'b1;
            end else if (st_q.state == ST_SHIFT) begin
                st_d.state = ST_IDLE;
                st_d.tx_done_flag  = 1'b1;
                st_d.sck   = 1'b1;
                ist_set[IRQ_DONE] = 1'b1;
            end
        end

        // rising edge of the own clock: receiver samples here
        if (rise_ev && !ext_mode) begin
            st_d.sck = 1'b1;
        end

        // disabled transmitter: stop, park the clock high, free the buffer
        if (!tx_on) begin
            st_d.state = ST_IDLE;
            st_d.sck   = 1'b1;
            st_d.tx_buffer_empty  = 1'b1;
            st_d.tx_done_flag  = 1'b1;
        end

        // clock pin direction follows the source select
        st_d.sck_oe = !st_d.ctl[CTL_SRC_HI];
        if (st_d.ctl[CTL_SRC_HI]) begin
            st_d.sck = 1'b1;
        end

        // sticky interrupt status, a set beats a clear
        st_d.ist = (st_q.ist & ~ist_clr) | ist_set;
        st_d.irq = |(st_d.ist & st_d.imask);
    end

    // ------------------------------------------------------------------
    // state register
    // ------------------------------------------------------------------
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            st_q          <= '0;
            st_q.fmt      <= FORMAT_RST;
            st_q.rate     <= RATE_RST;
            st_q.ctl      <= CONTROL_RST;
            st_q.hold     <= HOLDING_RST;
            st_q.shft     <= HOLDING_RST;
            st_q.tx_buffer_empty     <= 1'b1;
            st_q.tx_done_flag     <= 1'b1;
            st_q.state    <= ST_IDLE;
            st_q.sck      <= 1'b1;
            st_q.sck_oe   <= 1'b1;
            st_q.txd      <= 1'b1;
            st_q.ext_prev <= 1'b1;
            st_q.ist      <= IRQ_RST;
            st_q.imask    <= IRQ_RST;
        end else begin
            st_q <= st_d;
        end
    end

    // outputs straight from the state register
    assign wb_o.ack      = st_q.ack;
    assign wb_o.dat      = st_q.rdat;
    assign pins_o.txd    = st_q.txd;
    assign pins_o.sck    = st_q.sck;
    assign pins_o.sck_oe = st_q.sck_oe;
    assign rx_enable_o   = st_q.ctl[CTL_RX_EN];
    assign irq_o         = st_q.irq;

    // ------------------------------------------------------------------
    // checks
    // ------------------------------------------------------------------
    default clocking cb @(posedge clk_i); endclocking
    default disable iff (rst_i);

    logic hold_wr;
    logic rst_seen_q;
    assign hold_wr = wr && hit(wb_i.adr, IDX_HOLDING);
    always_ff @(posedge clk_i) begin
        rst_seen_q <= rst_i;
    end

    chk_off_idle: assert property (!tx_on |=> (st_q.state == ST_IDLE) && pins_o.sck)
        else $error("transmitter active while disabled");
    chk_rx_level: assert property (wr && hit(wb_i.adr, IDX_CONTROL) |=> rx_enable_o == $past(wb_i.dat[4]))
        else $error("rx enable not taken from control write");
    chk_clk_internal: assert property (!st_q.ctl[CTL_SRC_HI] |-> pins_o.sck_oe)
        else $error("internal clock but pin not driven");
    chk_clk_external: assert property (st_q.ctl[CTL_SRC_HI] |-> !pins_o.sck_oe)
        else $error("external clock but pin driven");
    chk_hold_refused: assert property (hold_wr && !st_q.tx_buffer_empty |=> $stable(st_q.hold))
        else $error("holding register took a byte while full");
    chk_load_frees: assert property (load_ev |=> st_q.tx_buffer_empty && st_q.state == ST_SHIFT && st_q.bitn == 3'h0)
        else $error("load did not free the buffer");
    chk_done_clear: assert property (st_q.state == ST_SHIFT |-> !st_q.tx_done_flag)
        else $error("done flag set while sending");
    chk_hold_reset: assert property (rst_seen_q |-> st_q.hold == HOLDING_RST)
        else $error("holding register not all ones after reset");
    chk_load_copy: assert property (load_ev |=> st_q.shft == $past(st_q.hold) && pins_o.txd == $past(st_q.hold[0]))
        else $error("shifter not loaded from holding register");
    chk_lsb_first: assert property (fall_ev && st_q.state == ST_SHIFT && st_q.bitn != 3'h7
        |=> pins_o.txd == $past(st_q.shft[1]) && st_q.bitn == $past(st_q.bitn) + 3'h1)
        else $error("bit order or count wrong");
    chk_no_gap: assert property (fall_ev && st_q.state == ST_SHIFT && st_q.bitn == 3'h7 && pending
        |=> st_q.state == ST_SHIFT && st_q.bitn == 3'h0)
        else $error("back to back frame broken");
    chk_end_hold: assert property (st_q.state == ST_IDLE && !pending && !hold_wr
        ##1 st_q.state == ST_IDLE |-> $stable(pins_o.txd) && pins_o.sck)
        else $error("data or clock moved after the frame");
    chk_eight_bits: assert property (load_ev |-> ##[1:1000] (st_q.bitn == 3'h7) || !tx_on)
        else $error("frame never reached its eighth bit");

    // bus answers once per request, one cycle later; rate and hand-over writes land
    chk_bus_answer: assert property (wb_i.cyc && wb_i.stb && !wb_o.ack |=> wb_o.ack)
        else $error("request not answered in the next cycle");
    chk_ack_pulse: assert property (wb_o.ack |=> !wb_o.ack)
        else $error("acknowledge held longer than one cycle");
    chk_rate_write: assert property (wr && hit(wb_i.adr, IDX_RATE) |=> st_q.rate == $past(wb_i.dat[7:0]))
        else $error("rate divisor write lost");
    chk_handover: assert property (wr && hit(wb_i.adr, IDX_FLAGS) && !wb_i.dat[FLG_EMPTY] && st_q.tx_buffer_empty && tx_on
        |=> !st_q.tx_buffer_empty)
        else $error("hand-over did not clear the empty flag");

    // a frame ends with the clock parked high and the data pin on the last bit
    chk_stop_state: assert property (fall_ev && st_q.state == ST_SHIFT && st_q.bitn == 3'h7 && !pending
        |=> st_q.tx_done_flag && st_q.state == ST_IDLE && pins_o.sck && $stable(pins_o.txd))
        else $error("frame did not stop cleanly");
    chk_idle_high: assert property (st_q.state == ST_IDLE |-> pins_o.sck)
        else $error("clock low while idle");

    // interrupt line follows status and mask, and a new event beats a clear
    chk_irq_level: assert property (irq_o == |(st_q.ist & st_q.imask))
        else $error("interrupt line does not match status and mask");
    chk_set_wins: assert property (load_ev && ist_clr[IRQ_EMPTY] |=> st_q.ist[IRQ_EMPTY])
        else $error("clear beat a new event");

    // main scenarios
    cov_single: cover property (load_ev ##[1:1000] (st_q.state == ST_IDLE && st_q.tx_done_flag));
    cov_back_to_back: cover property (fall_ev && st_q.bitn == 3'h7 && pending && st_q.state == ST_SHIFT);
    cov_external: cover property (ext_mode && load_ev);
    cov_irq: cover property ($rose(irq_o));
    cov_refused: cover property (hold_wr && !st_q.tx_buffer_empty);

endmodule : sync_serial_transmitter
`default_nettype wire

// ### sim/sync_rx_model.sv
// receiving end of the clocked serial link, with a clock source for external mode
`timescale 1ns/1ps
`default_nettype none
module sync_rx_model (
    input  wire logic clk_i,
    input  wire logic clr_i,
    input  wire logic sck_i,
    input  wire logic txd_i,
    input  wire logic ext_run_i,
    output logic      sck_o,
    output logic [7:0] byte_o,
    output int        count_o,
    output int        maxp_o
);
    logic       prev_q;
    logic       seen_q;
    logic [7:0] sh_q;
    int         bits_q;
    int         gap_q;
    int         div_q;
    // sample data on the rising serial clock, lsb first; longest gap between rises
    always_ff @(posedge clk_i) begin
        prev_q <= sck_i;
        gap_q  <= gap_q + 1;
        if (clr_i) begin
            seen_q  <= 1'b0;
            bits_q  <= 0;
            count_o <= 0;
            maxp_o  <= 0;
        end else if (sck_i && !prev_q) begin
            sh_q   <= {txd_i, sh_q[7:1]};
            bits_q <= (bits_q == 7) ? 0 : bits_q + 1;
            if (bits_q == 7) begin
                byte_o  <= {txd_i, sh_q[7:1]};
                count_o <= count_o + 1;
            end
            if (seen_q && gap_q > maxp_o) begin
                maxp_o <= gap_q;
            end
            seen_q <= 1'b1;
            gap_q  <= 1;
        end
    end
    // external clock, five cycles a half, pulled high while stopped
    always_ff @(posedge clk_i) begin
        div_q <= (!ext_run_i || div_q == 4) ? 0 : div_q + 1;
        sck_o <= !ext_run_i ? 1'b1 : ((div_q == 4) ? !sck_o : sck_o);
    end
endmodule : sync_rx_model
`default_nettype wire

// ### sim/sync_serial_transmitter_tb.sv
// self-checking bench of the clocked serial transmitter
`timescale 1ns/1ps
`default_nettype none
module sync_serial_transmitter_tb;
    import sync_tx_pkg::*;
    logic clk_i, rst_i, rx_en, irq, clr, ext_run, ext_sck, sck_w;
    wb_req_t      req;
    wb_rsp_t      rsp;
    serial_pins_t pins;
    logic [7:0]   rx_byte;
    int           rx_count, rx_maxp, cycles, num_errors, checked;

    // the clock wire follows whichever party drives it
    assign sck_w = pins.sck_oe ? pins.sck : ext_sck;
    sync_serial_transmitter uut (.clk_i(clk_i), .rst_i(rst_i), .wb_i(req), .wb_o(rsp), .sck_i(sck_w),
        .pins_o(pins), .rx_enable_o(rx_en), .irq_o(irq));
    sync_rx_model rx (.clk_i(clk_i), .clr_i(clr), .sck_i(sck_w), .txd_i(pins.txd), .ext_run_i(ext_run),
        .sck_o(ext_sck), .byte_o(rx_byte), .count_o(rx_count), .maxp_o(rx_maxp));

    initial begin
        clk_i = 1'b0;
        forever #10 clk_i = ~clk_i;
    end
    // cut a hang short
    always @(posedge clk_i) begin
        cycles <= cycles + 1;
        if (cycles == 20000) begin
            num_errors++;
            print_verdict();
        end
    end

    task automatic print_verdict;
        $display("checked %0d errors %0d", checked, num_errors);
        if (num_errors == 0 && checked > 0) $display("All tests passed");
        else $display("Some tests failed");
        $finish;
    endtask : print_verdict

    task automatic chk(input logic [7:0] got, input logic [7:0] exp);
        checked++;
        if (got !== exp) begin
            num_errors++;
            $display("Error at %0t: got %h expected %h", $time, got, exp);
        end
    endtask : chk

    // one classic cycle; ack and read data are taken at a rising edge, then the request is dropped
    task automatic bus(input logic w, input logic [23:0] idx, input logic [7:0] d, output logic [7:0] r);
        int n;
        n = 0;
        @(posedge clk_i);
        req <= '{cyc: 1'b1, stb: 1'b1, we: w, adr: {6'h00, idx, 2'b00}, sel: 4'h1, dat: {24'h0, d}};
        do begin
            @(posedge clk_i);
            n++;
        end while (rsp.ack !== 1'b1 && n < 20);
        chk(8'(n), 8'h02);
        r = rsp.dat[7:0];
        req.cyc <= 1'b0;
        req.stb <= 1'b0;
    endtask : bus

    task automatic wr(input logic [23:0] idx, input logic [7:0] d);
        logic [7:0] r;
        bus(1'b1, idx, d, r);
    endtask : wr

    task automatic rdchk(input logic [23:0] idx, input logic [7:0] exp);
        logic [7:0] r;
        bus(1'b0, idx, 8'h00, r);
        chk(r, exp);
    endtask : rdchk

    task automatic wait_flag(input int pos, input logic val);
        logic [7:0] r;
        int n;
        n = 0;
        do begin
            bus(1'b0, IDX_FLAGS, 8'h00, r);
            n++;
        end while (r[pos] !== val && n < 400);
        chk({7'h0, r[pos]}, {7'h0, val});
    endtask : wait_flag

    task automatic send(input logic [7:0] d);
        wr(IDX_HOLDING, d);
        wr(IDX_FLAGS, 8'h00);
    endtask : send

    task automatic clear_rx;
        @(posedge clk_i);
        clr <= 1'b1;
        @(posedge clk_i);
        clr <= 1'b0;
    endtask : clear_rx

    // ------------------------------------------------------------------
    // scenarios
    // ------------------------------------------------------------------
    task automatic t_reset;
        rdchk(IDX_HOLDING, 8'hff);
        rdchk(IDX_FLAGS, 8'h84);
        rdchk(IDX_CONTROL, 8'h00);
        rdchk(24'h000123, 8'h00);
        wr(IDX_RATE, 8'h0f);
        rdchk(IDX_RATE, 8'h0f);
    endtask : t_reset

    task automatic t_disabled;
        clear_rx();
        send(8'h5a);
        repeat (40) @(negedge clk_i);
        chk({7'h0, pins.sck}, 8'h01);
        chk(8'(rx_count), 8'h00);
        rdchk(IDX_FLAGS, 8'h84);
        wr(IDX_CONTROL, 8'h10);
        @(negedge clk_i);
        chk({7'h0, rx_en}, 8'h01);
        wr(IDX_CONTROL, 8'h00);
        @(negedge clk_i);
        chk({7'h0, rx_en}, 8'h00);
    endtask : t_disabled

    task automatic t_single;
        clear_rx();
        wr(IDX_CONTROL, 8'h20);
        @(negedge clk_i);
        chk({7'h0, pins.sck_oe}, 8'h01);
        send(8'h5a);
        wait_flag(FLG_DONE, 1'b1);
        chk(rx_byte, 8'h5a);
        chk(8'(rx_maxp), 8'd64);
        chk({6'h0, pins.sck, pins.txd}, 8'h02);
    endtask : t_single

    task automatic t_back;
        wr(IDX_RATE, 8'h07);
        clear_rx();
        send(8'ha5);
        wait_flag(FLG_EMPTY, 1'b1);
        send(8'h3c);
        wr(IDX_HOLDING, 8'h11);
        rdchk(IDX_HOLDING, 8'h3c);
        rdchk(IDX_FLAGS, 8'h00);
        wait_flag(FLG_DONE, 1'b1);
        chk(8'(rx_count), 8'h02);
        chk(rx_byte, 8'h3c);
        chk(8'(rx_maxp), 8'd32);
        chk({7'h0, irq}, 8'h00);
        wr(IDX_IRQ_MASK, 8'h02);
        @(negedge clk_i);
        chk({7'h0, irq}, 8'h01);
        wr(IDX_IRQ_STAT, 8'h03);
        @(negedge clk_i);
        chk({7'h0, irq}, 8'h00);
    endtask : t_back

    task automatic t_external;
        clear_rx();
        wr(IDX_CONTROL, 8'h22);
        @(negedge clk_i);
        chk({7'h0, pins.sck_oe}, 8'h00);
        send(8'h96);
        @(posedge clk_i);
        ext_run <= 1'b1;
        wait_flag(FLG_DONE, 1'b1);
        ext_run <= 1'b0;
        chk(rx_byte, 8'h96);
    endtask : t_external

    initial begin
        req = '0;
        rst_i = 1'b1;
        clr = 1'b0;
        ext_run = 1'b0;
        cycles = 0;
        num_errors = 0;
        checked = 0;
        repeat (20) @(posedge clk_i);
        rst_i <= 1'b0;
        t_reset();
        t_disabled();
        t_single();
        t_back();
        t_external();
        print_verdict();
    end
endmodule : sync_serial_transmitter_tb
`default_nettype wire
